// ===== core/cad_array_access.sv
// Direct software access path into the cache tag and data arrays.
//
// Functional notes
// - Only privileged loads and stores reach arrays.
// - Tag window F0xxxxxx, data window F1xxxxxx.
// - Tag entry index from address bits 11:4.
// - Two-bit way field picks way 0 to 3.
// - Top byte F0 selects the tag array.
// - Compare-flag write updates matching way only.
// - Plain tag write updates indexed way directly.
// - Written tag translated when MMU is on.
// - Tag read returns tag, valid, dirty, LRU.
// - Clearing valid on dirty line writes back.
// - Line fill stores zero in top tag bits.
// - Longword slot from address bits 3:2.
// - Data way field decoded like tag way.
// - Top byte F1 selects the data array.
// - Data access moves exactly one addressed longword.
// - Hit needs tag match and valid set.
// - Write-back via one-line buffer; fetch first.
module cad_array_access #(
    parameter int WAYS = 4
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    // Core request
    input  wire logic                       reqValid,
    input  wire logic                       reqWrite,
    input  wire logic                       reqPriv,
    input  wire logic                       reqFetch,
    input  wire logic [1:0]                 reqSize,
    input  wire logic [31:0]                reqAddr,
    input  wire logic [31:0]                reqWdata,
    output logic                            reqReady,
    // Core answer
    output logic                            rspValid,
    output logic                            rspError,
    output logic [31:0]                     rspData,
    // Address translation
    input  wire logic                       mmuEnable,
    output logic                            xlatReq,
    output logic [cad_pkg::TAG_W-1:0]       xlatVpn,
    input  wire logic                       xlatAck,
    input  wire logic [cad_pkg::TAG_W-1:0]  xlatPpn,
    // Miss fill
    input  wire logic                       fillValid,
    input  wire logic [cad_pkg::IDX_W-1:0]  fillIndex,
    input  wire logic [cad_pkg::WAY_W-1:0]  fillWay,
    input  wire logic [cad_pkg::TAG_W-1:0]  fillTag,
    input  wire logic [127:0]               fillData,
    input  wire logic                       fetchBusy,
    // Hit search
    input  wire logic                       lookupValid,
    input  wire logic [cad_pkg::IDX_W-1:0]  lookupIndex,
    input  wire logic [cad_pkg::TAG_W-1:0]  lookupTag,
    output logic                            lookupDone,
    output logic                            lookupHit,
    output logic [cad_pkg::WAY_W-1:0]       lookupWay,
    // Write-back buffer drain
    output logic                            wbValid,
    output logic [cad_pkg::WBA_W-1:0]       wbAddr,
    output logic [127:0]                    wbData,
    input  wire logic                       wbReady
);

    if (WAYS != cad_pkg::NUM_WAYS) begin : g_chk
        $error("WAYS must match the two-bit way field");
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [cad_pkg::TAG_W-1:0] tagArr   [cad_pkg::NUM_SETS][WAYS];
    logic                      validArr [cad_pkg::NUM_SETS][WAYS];
    logic                      dirtyArr [cad_pkg::NUM_SETS][WAYS];
    logic [cad_pkg::LRU_W-1:0] lruArr   [cad_pkg::NUM_SETS];
    logic [31:0]               dataArr  [cad_pkg::NUM_SETS][WAYS][cad_pkg::LINE_WORDS];

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    cad_pkg::cad_state_t        state_q;
    cad_pkg::cad_state_t        state_d;
    logic                       reqReady_q;
    logic [7:0]                 sel;
    logic [cad_pkg::IDX_W-1:0]  idx;
    logic [cad_pkg::WAY_W-1:0]  way;
    logic [cad_pkg::LW_W-1:0]   lw;
    logic                       isTag;
    logic                       isData;
    logic                       legal;
    logic                       reqTake;
    logic                       tagWrStart;

    assign sel     = reqAddr[cad_pkg::SEL_HI:cad_pkg::SEL_LO];
    assign idx     = reqAddr[cad_pkg::IDX_HI:cad_pkg::IDX_LO];
    assign way     = reqAddr[cad_pkg::WAY_HI:cad_pkg::WAY_LO];
    assign lw      = reqAddr[cad_pkg::LW_HI:cad_pkg::LW_LO];
    assign isTag   = (sel == cad_pkg::SEL_TAG);
    assign isData  = (sel == cad_pkg::SEL_DATA);
    assign legal   = reqPriv && !reqFetch && (reqSize == cad_pkg::SIZE_LONG)
                     && (isTag || isData);
    assign reqTake = reqValid && reqReady_q;
    assign tagWrStart = reqTake && legal && isTag && reqWrite;
    assign reqReady   = reqReady_q;

    // ------------------------------------------------------------------
    // Tag write execution
    // ------------------------------------------------------------------
    logic [cad_pkg::IDX_W-1:0]  idx_q;
    logic [cad_pkg::WAY_W-1:0]  way_q;
    logic                       assoc_q;
    logic [31:0]                wdata_q;
    logic [cad_pkg::TAG_W-1:0]  ptag_q;
    logic [WAYS-1:0]            hitVec;
    logic [WAYS-1:0]            lkVec;
    logic [cad_pkg::WAY_W-1:0]  hitWay;
    logic [cad_pkg::WAY_W-1:0]  lkWay;
    logic [cad_pkg::WAY_W-1:0]  useWay;
    logic                       doWrite;
    logic                       newValid;
    logic                       needWb;
    logic                       stall;
    logic                       commit;
    logic                       finish;
    logic                       wbFull_q;
    logic                       wbTake;

    for (genvar w = 0; w < WAYS; w++) begin : g_way
        cad_way_match #(.TAG_W(cad_pkg::TAG_W)) u_wr (
            .storedTag   (tagArr[idx_q][w]),
            .storedValid (validArr[idx_q][w]),
            .probeTag    (ptag_q),
            .match       (hitVec[w])
        );
        cad_way_match #(.TAG_W(cad_pkg::TAG_W)) u_lk (
            .storedTag   (tagArr[lookupIndex][w]),
            .storedValid (validArr[lookupIndex][w]),
            .probeTag    (lookupTag),
            .match       (lkVec[w])
        );
    end

    function automatic logic [cad_pkg::WAY_W-1:0] firstWay(input logic [WAYS-1:0] v);
        logic [cad_pkg::WAY_W-1:0] r;
        r = '0;
        for (int i = WAYS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = cad_pkg::WAY_W'(i);
            end
        end
        return r;
    endfunction : firstWay

    assign hitWay   = firstWay(hitVec);
    assign lkWay    = firstWay(lkVec);
    assign useWay   = assoc_q ? hitWay : way_q;
    assign doWrite  = assoc_q ? (|hitVec) : 1'b1;
    assign newValid = wdata_q[cad_pkg::VALID_BIT];
    assign needWb   = doWrite && validArr[idx_q][useWay] && dirtyArr[idx_q][useWay]
                      && !newValid;
    assign stall    = needWb && wbFull_q;
    assign finish   = (state_q == cad_pkg::S_EXEC) && !stall;
    assign commit   = finish && doWrite;
    assign wbTake   = wbValid && wbReady;

    // ------------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            cad_pkg::S_IDLE: begin
                if (tagWrStart) begin
                    state_d = mmuEnable ? cad_pkg::S_XLAT : cad_pkg::S_EXEC;
                end
            end
            cad_pkg::S_XLAT: begin
                if (xlatAck) begin
                    state_d = cad_pkg::S_EXEC;
                end
            end
            cad_pkg::S_EXEC: begin
                if (!stall) begin
                    state_d = cad_pkg::S_IDLE;
                end
            end
            default: state_d = cad_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q    <= cad_pkg::S_IDLE;
            reqReady_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            reqReady_q <= (state_d == cad_pkg::S_IDLE) && !tagWrStart;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            idx_q   <= '0;
            way_q   <= '0;
            assoc_q <= 1'b0;
            wdata_q <= '0;
            ptag_q  <= '0;
        end else if (tagWrStart) begin
            idx_q   <= idx;
            way_q   <= way;
            assoc_q <= reqAddr[cad_pkg::ASSOC_BIT];
            wdata_q <= reqWdata;
            ptag_q  <= reqWdata[cad_pkg::TAG_HI:cad_pkg::TAG_LO];
        end else if (state_q == cad_pkg::S_XLAT && xlatAck) begin
            ptag_q  <= xlatPpn;
        end
    end

    // Translation request stands until the acknowledge.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            xlatReq <= 1'b0;
            xlatVpn <= '0;
        end else if (tagWrStart && mmuEnable) begin
            xlatReq <= 1'b1;
            xlatVpn <= reqWdata[cad_pkg::TAG_HI:cad_pkg::TAG_LO];
        end else if (xlatAck) begin
            xlatReq <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Tag array state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int s = 0; s < cad_pkg::NUM_SETS; s++) begin
                lruArr[s] <= cad_pkg::LRU_RESET;
                for (int w = 0; w < WAYS; w++) begin
                    validArr[s][w] <= 1'b0;
                    dirtyArr[s][w] <= 1'b0;
                end
            end
        end else begin
            if (fillValid) begin
                validArr[fillIndex][fillWay] <= 1'b1;
                dirtyArr[fillIndex][fillWay] <= 1'b0;
            end
            if (commit) begin
                validArr[idx_q][useWay] <= newValid;
                dirtyArr[idx_q][useWay] <= wdata_q[cad_pkg::DIRTY_BIT];
                lruArr[idx_q]           <= wdata_q[cad_pkg::LRU_HI:cad_pkg::LRU_LO];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (fillValid) begin
            tagArr[fillIndex][fillWay] <= {{cad_pkg::SHADOW_W{1'b0}},
                fillTag[cad_pkg::TAG_W-cad_pkg::SHADOW_W-1:0]};
        end
        if (commit) begin
            tagArr[idx_q][useWay] <= ptag_q;
        end
    end

    // ------------------------------------------------------------------
    // Data array
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (fillValid) begin
            for (int k = 0; k < cad_pkg::LINE_WORDS; k++) begin
                dataArr[fillIndex][fillWay][k] <= fillData[32*k +: 32];
            end
        end
        if (reqTake && legal && isData && reqWrite) begin
            dataArr[idx][way][lw] <= reqWdata;
        end
    end

    // ------------------------------------------------------------------
    // Answer to the core
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rspValid <= 1'b0;
            rspError <= 1'b0;
            rspData  <= '0;
        end else begin
            rspValid <= 1'b0;
            rspError <= 1'b0;
            if (reqTake && !legal) begin
                rspValid <= 1'b1;
                rspError <= 1'b1;
                rspData  <= '0;
            end else if (reqTake && !reqWrite && isTag) begin
                rspValid <= 1'b1;
                rspData  <= {tagArr[idx][way], lruArr[idx], 2'h0,
                             dirtyArr[idx][way], validArr[idx][way]};
            end else if (reqTake && !reqWrite) begin
                rspValid <= 1'b1;
                rspData  <= dataArr[idx][way][lw];
            end else if (reqTake && isData) begin
                rspValid <= 1'b1;
            end else if (finish) begin
                rspValid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Hit search
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lookupDone <= 1'b0;
            lookupHit  <= 1'b0;
            lookupWay  <= '0;
        end else begin
            lookupDone <= lookupValid;
            lookupHit  <= lookupValid && (|lkVec);
            lookupWay  <= lkWay;
        end
    end

    // ------------------------------------------------------------------
    // Write-back buffer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wbFull_q <= 1'b0;
            wbValid  <= 1'b0;
            wbAddr   <= '0;
            wbData   <= '0;
        end else begin
            if (commit && needWb) begin
                wbFull_q <= 1'b1;
                wbAddr   <= {tagArr[idx_q][useWay], idx_q[cad_pkg::IDX_LOW_W-1:0]};
                for (int k = 0; k < cad_pkg::LINE_WORDS; k++) begin
                    wbData[32*k +: 32] <= dataArr[idx_q][useWay][k];
                end
            end else if (wbTake) begin
                wbFull_q <= 1'b0;
            end
            wbValid <= ((commit && needWb) || (wbFull_q && !wbTake)) && !fetchBusy;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_tagWrite;
        tagWrStart && !mmuEnable;
    endsequence

    sequence s_execDone;
        (state_q == cad_pkg::S_EXEC && !stall) ##1 rspValid;
    endsequence

    chk_unpriv_refused: assert property (reqTake && !reqPriv |=> rspValid && rspError)
        else $error("unprivileged access was not refused");
    chk_window_decode: assert property (reqTake && reqPriv && !isTag && !isData
                                        |=> rspError)
        else $error("access outside both windows was not refused");
    chk_tag_read_word: assert property (reqTake && legal && isTag && !reqWrite
        |=> rspValid && rspData[cad_pkg::VALID_BIT] == $past(validArr[idx][way])
            && rspData[cad_pkg::LRU_HI:cad_pkg::LRU_LO] == $past(lruArr[idx]))
        else $error("tag read word does not match the entry");
    chk_data_write: assert property (reqTake && legal && isData && reqWrite
        |=> rspValid && dataArr[$past(idx)][$past(way)][$past(lw)] == $past(reqWdata))
        else $error("data write did not land in the addressed longword");
    chk_direct_write: assert property (s_tagWrite ##0 !reqAddr[cad_pkg::ASSOC_BIT]
        ##1 s_execDone |-> validArr[idx_q][way_q] == wdata_q[cad_pkg::VALID_BIT])
        else $error("direct tag write did not update the indexed way");
    chk_assoc_miss: assert property (state_q == cad_pkg::S_EXEC && assoc_q && !(|hitVec)
        && !fillValid |=> $stable(validArr[idx_q][way_q]) && $stable(lruArr[idx_q]))
        else $error("compare write on a miss changed the set");
    chk_xlat_issue: assert property (tagWrStart && mmuEnable
        |=> xlatReq && state_q == cad_pkg::S_XLAT)
        else $error("tag write with MMU on did not request translation");
    chk_fill_shadow: assert property (fillValid |=> tagArr[$past(fillIndex)][$past(fillWay)]
        [cad_pkg::TAG_W-1 -: cad_pkg::SHADOW_W] == '0)
        else $error("fill stored nonzero shadow tag bits");
    chk_wb_capture: assert property (commit && needWb |=> wbFull_q)
        else $error("dirty line cleared without write-back");
    chk_fetch_first: assert property (fetchBusy |=> !wbValid)
        else $error("write-back drain while a fetch is in progress");
    chk_lookup_hit: assert property (lookupValid |=> lookupDone
        && lookupHit == $past(|lkVec))
        else $error("hit flag disagrees with valid tag match");

endmodule : cad_array_access

// ===== core/cad_pkg.sv
// Constants, field layouts and state codes for the cache array access block.
package cad_pkg;

    // ------------------------------------------------------------------
    // Window selectors and address fields
    // ------------------------------------------------------------------
    localparam logic [7:0] SEL_TAG   = 8'hf0;
    localparam logic [7:0] SEL_DATA  = 8'hf1;
    localparam int         SEL_HI    = 31;
    localparam int         SEL_LO    = 24;
    localparam int         IDX_HI    = 11;
    localparam int         IDX_LO    = 4;
    localparam int         WAY_HI    = 13;
    localparam int         WAY_LO    = 12;
    localparam int         LW_HI     = 3;
    localparam int         LW_LO     = 2;
    localparam int         ASSOC_BIT = 3;

    // ------------------------------------------------------------------
    // Tag array data word layout
    // ------------------------------------------------------------------
    localparam int TAG_HI    = 31;
    localparam int TAG_LO    = 10;
    localparam int LRU_HI    = 9;
    localparam int LRU_LO    = 4;
    localparam int DIRTY_BIT = 1;
    localparam int VALID_BIT = 0;
    localparam int SHADOW_W  = 3;

    // ------------------------------------------------------------------
    // Geometry and access size
    // ------------------------------------------------------------------
    localparam int         TAG_W      = TAG_HI - TAG_LO + 1;
    localparam int         LRU_W      = LRU_HI - LRU_LO + 1;
    localparam int         IDX_W      = IDX_HI - IDX_LO + 1;
    localparam int         WAY_W      = WAY_HI - WAY_LO + 1;
    localparam int         LW_W       = LW_HI - LW_LO + 1;
    localparam int         NUM_SETS   = 1 << IDX_W;
    localparam int         NUM_WAYS   = 1 << WAY_W;
    localparam int         LINE_WORDS = 1 << LW_W;
    localparam int         IDX_LOW_W  = TAG_LO - IDX_LO;
    localparam int         WBA_W      = TAG_W + IDX_LOW_W;
    localparam logic [1:0] SIZE_LONG  = 2'h2;
    localparam logic [LRU_W-1:0] LRU_RESET = 6'h00;

    // ------------------------------------------------------------------
    // Control states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_XLAT = 3'b010,
        S_EXEC = 3'b100
    } cad_state_t;

endpackage : cad_pkg

// ===== core/cad_way_match.sv
// Tag comparator for one way of the indexed set.
module cad_way_match #(
    parameter int TAG_W = 22
) (
    // Stored entry
    input  wire logic [TAG_W-1:0] storedTag,
    input  wire logic             storedValid,
    // Probe
    input  wire logic [TAG_W-1:0] probeTag,
    output logic                  match
);
    assign match = storedValid && (storedTag == probeTag);
endmodule : cad_way_match

// ===== tb/cad_core_model.sv
// Core-side model that issues loads and stores with a given privilege, fetch flag, size and address.
module cad_core_model (
    // Clock
    input  wire logic        clk_sys,
    // Request
    output logic             reqValid,
    output logic             reqWrite,
    output logic             reqPriv,
    output logic             reqFetch,
    output logic [1:0]       reqSize,
    output logic [31:0]      reqAddr,
    output logic [31:0]      reqWdata,
    input  wire logic        reqReady,
    // Answer
    input  wire logic        rspValid,
    input  wire logic        rspError,
    input  wire logic [31:0] rspData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqPriv  = 1'b1;
        reqFetch = 1'b0;
        reqSize  = cad_pkg::SIZE_LONG;
        reqAddr  = 32'h0;
        reqWdata = 32'h0;
    end

    // One access: held until taken, then address and write data are inverted so stale values never count.
    task automatic access(input logic wr, input logic priv, input logic fetch,
                          input logic [1:0] size, input logic [31:0] addr,
                          input logic [31:0] wdata, output logic [31:0] data,
                          output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqPriv  <= priv;
        reqFetch <= fetch;
        reqSize  <= size;
        reqAddr  <= addr;
        reqWdata <= wdata;
        do begin @(posedge clk_sys); n++; end while (reqReady !== 1'b1 && n < 64);
        reqValid <= 1'b0;
        reqAddr  <= ~addr;
        reqWdata <= ~wdata;
        do begin @(posedge clk_sys); n++; end while (rspValid !== 1'b1 && n < 128);
        data = rspData;
        err  = rspError;
    endtask : access

endmodule : cad_core_model

// ===== tb/test_cad_array_access.sv
// Self-checking testbench for the cache array direct access block.
module test_cad_array_access;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic                        clk_sys = 1'b0;
    logic                        rst_n = 1'b0;
    logic                        reqValid, reqWrite, reqPriv, reqFetch, reqReady;
    logic                        rspValid, rspError, lookupDone, lookupHit, wbValid, xlatReq;
    logic [1:0]                  reqSize, lookupWay;
    logic [31:0]                 reqAddr, reqWdata, rspData, rdata;
    logic                        rerr, mmuEnable = 1'b0, xlatAck = 1'b0, fillValid = 1'b0;
    logic                        fetchBusy = 1'b0, lookupValid = 1'b0, wbReady = 1'b0;
    logic [cad_pkg::TAG_W-1:0]   xlatVpn, xlatPpn = '0, fillTag = '0, lookupTag = '0;
    logic [cad_pkg::IDX_W-1:0]   fillIndex = '0, lookupIndex = '0;
    logic [cad_pkg::WAY_W-1:0]   fillWay = '0;
    logic [127:0]                fillData = '0, wbData;
    logic [cad_pkg::WBA_W-1:0]   wbAddr;
    logic [2:0]                  xCnt = 3'h0;
    int                          err_total = 0;
    int                          checks_done = 0;
    localparam logic [7:0]       IDX = 8'h5a;

    cad_core_model core (.clk_sys, .reqValid, .reqWrite, .reqPriv, .reqFetch, .reqSize,
                         .reqAddr, .reqWdata, .reqReady, .rspValid, .rspError, .rspData);

    cad_array_access #(.WAYS(4)) uut (.clk_sys, .rst_n, .reqValid, .reqWrite, .reqPriv,
        .reqFetch, .reqSize, .reqAddr, .reqWdata, .reqReady, .rspValid, .rspError, .rspData,
        .mmuEnable, .xlatReq, .xlatVpn, .xlatAck, .xlatPpn, .fillValid, .fillIndex, .fillWay,
        .fillTag, .fillData, .fetchBusy, .lookupValid, .lookupIndex, .lookupTag, .lookupDone,
        .lookupHit, .lookupWay, .wbValid, .wbAddr, .wbData, .wbReady);

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // Translator answers four cycles after a request, once per request.
    always @(posedge clk_sys) begin
        xlatAck <= 1'b0;
        if (xlatReq !== 1'b1 || xlatAck) begin
            xCnt <= 3'h0;
        end else if (xCnt == 3'h3) begin
            xlatAck <= 1'b1;
            xlatPpn <= xlatVpn ^ 22'h000aa0;
        end else begin
            xCnt <= xCnt + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] ad(input logic [7:0] s, input int w, input int l,
                                       input logic [7:0] i);
        return {s, 10'h0, 2'(w), i, 2'(l), 2'h0};
    endfunction : ad

    function automatic logic [31:0] dv(input int w, input int l);
        return {8'ha5, 6'h0, 2'(w), 6'h0, 2'(l), 8'h3c};
    endfunction : dv

    function automatic logic [31:0] tw(input logic [21:0] t, input logic d, input logic v);
        return {t, 6'h2a, 2'h0, d, v};
    endfunction : tw

    function automatic logic [21:0] tg(input int w);
        return {20'h01234, 2'(w)};
    endfunction : tg

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        core.access(1'b1, 1'b1, 1'b0, cad_pkg::SIZE_LONG, a, d, rdata, rerr);
        chk(rerr, 1'b0);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        core.access(1'b0, 1'b1, 1'b0, cad_pkg::SIZE_LONG, a, 32'h0, rdata, rerr);
        chk({rerr, rdata}, {1'b0, e});
    endtask : rd

    task automatic lk(input logic [21:0] t, input logic h, input logic [1:0] w);
        @(posedge clk_sys);
        lookupValid <= 1'b1;
        lookupIndex <= IDX;
        lookupTag   <= t;
        @(posedge clk_sys);
        lookupValid <= 1'b0;
        @(posedge clk_sys);
        chk({lookupDone, lookupHit, h ? lookupWay : w}, {1'b1, h, w});
    endtask : lk

    task automatic results();
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int w = 0; w < 4; w++) for (int l = 0; l < 4; l++) wr(ad(8'hf1, w, l, IDX), dv(w, l));
        for (int w = 0; w < 4; w++) for (int l = 0; l < 4; l++) rd(ad(8'hf1, w, l, IDX), dv(w, l));
        core.access(1'b1, 1'b0, 1'b0, 2'h2, ad(8'hf1, 0, 0, IDX), 32'h0, rdata, rerr);
        chk(rerr, 1'b1);
        core.access(1'b0, 1'b1, 1'b1, 2'h2, ad(8'hf1, 0, 0, IDX), 32'h0, rdata, rerr);
        chk(rerr, 1'b1);
        core.access(1'b1, 1'b1, 1'b0, 2'h1, ad(8'hf1, 0, 0, IDX), 32'h0, rdata, rerr);
        chk(rerr, 1'b1);
        core.access(1'b1, 1'b1, 1'b0, 2'h2, ad(8'hf2, 0, 0, IDX), 32'h0, rdata, rerr);
        chk(rerr, 1'b1);
        rd(ad(8'hf1, 0, 0, IDX), dv(0, 0));
        for (int w = 0; w < 4; w++) wr(ad(8'hf0, w, 0, IDX), tw(tg(w), 1'b1, 1'b1));
        for (int w = 0; w < 4; w++) rd(ad(8'hf0, w, 0, IDX), tw(tg(w), 1'b1, 1'b1));
        lk(tg(2), 1'b1, 2'h2);
        lk(22'h3ffff0, 1'b0, 2'h0);
        wr(ad(8'hf0, 0, 2, IDX), tw(22'h000777, 1'b1, 1'b0));
        rd(ad(8'hf0, 0, 0, IDX), tw(tg(0), 1'b1, 1'b1));
        fetchBusy <= 1'b1;
        wr(ad(8'hf0, 3, 2, IDX), tw(tg(1), 1'b0, 1'b0));
        rd(ad(8'hf0, 1, 0, IDX), tw(tg(1), 1'b0, 1'b0));
        rd(ad(8'hf0, 3, 0, IDX), tw(tg(3), 1'b1, 1'b1));
        lk(tg(1), 1'b0, 2'h0);
        chk(wbValid, 1'b0);
        fetchBusy <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(wbValid, 1'b1);
        chk(wbAddr, {tg(1), IDX[5:0]});
        chk(wbData, {dv(1, 3), dv(1, 2), dv(1, 1), dv(1, 0)});
        wbReady <= 1'b1;
        @(posedge clk_sys);
        wbReady <= 1'b0;
        @(posedge clk_sys);
        chk(wbValid, 1'b0);
        mmuEnable <= 1'b1;
        wr(ad(8'hf0, 0, 0, IDX), tw(22'h000555, 1'b0, 1'b1));
        mmuEnable <= 1'b0;
        rd(ad(8'hf0, 0, 0, IDX), tw(22'h000555 ^ 22'h000aa0, 1'b0, 1'b1));
        fillValid <= 1'b1;
        fillIndex <= 8'hc3;
        fillWay   <= 2'h2;
        fillTag   <= 22'h3f0123;
        fillData  <= {32'h4444_0004, 32'h3333_0003, 32'h2222_0002, 32'h1111_0001};
        @(posedge clk_sys);
        fillValid <= 1'b0;
        core.access(1'b0, 1'b1, 1'b0, 2'h2, ad(8'hf0, 2, 0, 8'hc3), 32'h0, rdata, rerr);
        chk(rdata & 32'hfffffc03, {22'h070123, 10'h001});
        rd(ad(8'hf1, 2, 2, 8'hc3), 32'h3333_0003);
        results();
    end

endmodule : test_cad_array_access
